/* common/acv_pkg.sv */
// Package with register map, field layout, timing and shared types for the converter control
package acv_pkg;

   // Register byte offsets
   localparam logic [11:0] ACV_STATUS_CONTROL_OFF = 12'h000;
   localparam logic [11:0] ACV_RESULT_HIGH_OFF    = 12'h004;
   localparam logic [11:0] ACV_RESULT_LOW_OFF     = 12'h008;
   localparam logic [11:0] ACV_CONFIG_OFF         = 12'h00C;
   localparam logic [11:0] ACV_IRQ_STATUS_OFF     = 12'h010;
   localparam logic [11:0] ACV_IRQ_MASK_OFF       = 12'h014;
   localparam logic [11:0] ACV_SAR_DATA_OFF       = 12'h018;

   // Status/control field positions
   localparam int ACV_CH_LSB      = 0;
   localparam int ACV_CH_W        = 5;
   localparam int ACV_CONT_BIT    = 5;
   localparam int ACV_IEN_BIT     = 6;
   localparam int ACV_COMPLETE_BIT = 7;

   // Config field positions
   localparam int ACV_ASYNC_BIT   = 0;
   localparam int ACV_LONG_BIT    = 1;
   localparam int ACV_HWTRIG_BIT  = 2;
   localparam int ACV_BUSY_BIT    = 3;
   localparam int ACV_LOWPWR_BIT  = 4;
   localparam int ACV_DIV_LSB     = 8;
   localparam int ACV_DIV_W       = 8;

   // Interrupt status layout
   localparam int ACV_EV_DONE     = 0;
   localparam int ACV_EV_ABORT    = 1;
   localparam int ACV_EV_W        = 2;

   // Reset values
   localparam logic [7:0] ACV_SC_RESET  = 8'h1F;
   localparam logic [7:0] ACV_DIV_RESET = 8'h03;

   // Channel code that turns the converter off
   localparam logic [4:0] ACV_CH_OFF = 5'h1F;

   // Sample window in half converter-clock cycles: 3.5 and 23.5 cycles
   localparam int ACV_SAMPLE_SHORT_HALF = 7;
   localparam int ACV_SAMPLE_LONG_HALF  = 47;
   localparam int ACV_RES_BITS          = 10;
   localparam int ACV_CODES             = 1024;

   typedef enum logic [2:0]
   {
      ACV_IDLE   = 3'b000,
      ACV_SAMPLE = 3'b001,
      ACV_CONV   = 3'b011,
      ACV_XFER   = 3'b010
   } acv_state_t;

   // Converter configuration carried as one group
   typedef struct packed
   {
      logic       async_clock_select;
      logic       long_sample_select;
      logic       hw_trigger_mode_bit;
      logic [7:0] div;
   } acv_cfg_t;

endpackage : acv_pkg

/* design/acv_clkdiv.sv */
// Enable divider producing half converter-clock pulses
`timescale 1ns/1ps
`default_nettype none
module acv_clkdiv
   import acv_pkg::*;
#(
   parameter int DW = 8
)
(
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          run,
   input  wire logic [DW-1:0] div,
   output logic              half_tick
);
   logic [DW-1:0] cnt_q;
   logic [DW-1:0] cnt_d;
   logic          wrap;

   // Count down reload; each wrap is one half converter-clock cycle
   assign wrap  = (cnt_q == '0);
   assign cnt_d = wrap ? div : cnt_q - DW'(1);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_q     <= '0;
         half_tick <= 1'b0;
      end
      else
      begin
         cnt_q     <= run ? cnt_d : div;
         half_tick <= run & wrap;
      end
   end
endmodule : acv_clkdiv
`default_nettype wire

/* design/acv_round.sv */
// Rounds the extended approximation word to the nearest result code
`timescale 1ns/1ps
`default_nettype none
module acv_round
   import acv_pkg::*;
#(
   parameter int RW = 10
)
(
   input  wire logic [RW:0]   raw,
   output logic      [RW-1:0] code
);
   logic [RW:0] sum;

   // Add half a step then saturate at the top code
   assign sum  = {1'b0, raw[RW:1]} + {{RW{1'b0}}, raw[0]};
   assign code = sum[RW] ? {RW{1'b1}} : sum[RW-1:0];
endmodule : acv_round
`default_nettype wire

/* design/acv_ctrl.sv */
// Converter control: conversion sequencing, low-power modes, interrupts and APB registers
`timescale 1ns/1ps
`default_nettype none
module acv_ctrl
   import acv_pkg::*;
#(
   parameter int RES_W = ACV_RES_BITS
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        stop_mode,
   input  wire logic        wait_mode,
   input  wire logic        hw_trigger,
   input  wire logic        comparator_in,
   output logic      [RES_W:0] sar_trial,
   output logic             converter_on,
   output logic      [4:0]  channel_out,
   output logic             conv_irq,
   output logic             irq
);
   // Synchronised pin inputs
   logic [1:0] stop_s_q;
   logic [1:0] trig_s_q;
   logic [1:0] cmp_s_q;
   logic       trig_prev_q;

   // Software registers
   logic [7:0]        sc_q;
   acv_cfg_t          cfg_q;
   logic [RES_W-1:0]  result_q;
   logic [ACV_EV_W-1:0] ist_q;
   logic [ACV_EV_W-1:0] imask_q;
   logic              conv_irq_q;
   logic              stopped_q;

   // Conversion engine
   acv_state_t        state_q;
   logic [5:0]        half_cnt_q;
   logic [RES_W:0]    sar_q;
   logic [RES_W:0]    bit_q;
   logic [RES_W-1:0]  rounded;
   logic              half_tick;

   // Bus decode
   wire acc      = psel & penable;
   wire wr       = acc & pwrite;
   wire rd       = acc & ~pwrite;
   wire sel_sc   = (paddr == ACV_STATUS_CONTROL_OFF);
   wire sel_rh   = (paddr == ACV_RESULT_HIGH_OFF);
   wire sel_rl   = (paddr == ACV_RESULT_LOW_OFF);
   wire sel_cfg  = (paddr == ACV_CONFIG_OFF);
   wire sel_ist  = (paddr == ACV_IRQ_STATUS_OFF);
   wire sel_msk  = (paddr == ACV_IRQ_MASK_OFF);
   wire sel_sar  = (paddr == ACV_SAR_DATA_OFF);
   wire mapped   = sel_sc | sel_rh | sel_rl | sel_cfg | sel_ist | sel_msk | sel_sar;
   wire sc_wr    = wr & sel_sc;
   wire rl_rd    = rd & sel_rl;
   wire rh_rd    = rd & sel_rh;

   // Field views
   wire [4:0] chan      = sc_q[ACV_CH_LSB +: ACV_CH_W];
   wire       cont_sel  = sc_q[ACV_CONT_BIT];
   wire       ien       = sc_q[ACV_IEN_BIT];
   wire [4:0] new_chan  = pwdata[ACV_CH_LSB +: ACV_CH_W];
   wire       stop_now  = stop_s_q[1];
   wire       trig_edge = trig_s_q[1] & ~trig_prev_q;

   // Stop without async clock kills conversions; with it they go on
   wire stop_abort = stop_now & ~cfg_q.async_clock_select;
   wire busy       = (state_q != ACV_IDLE);
   wire sc_start   = sc_wr & (new_chan != ACV_CH_OFF);
   wire hw_start   = cfg_q.hw_trigger_mode_bit & trig_edge & ~stopped_q
                     & (chan != ACV_CH_OFF);
   wire done       = (state_q == ACV_XFER);
   // Continuous restarts; wait mode does not gate the engine
   wire cont_next  = done & cont_sel & ~sc_wr & ~stop_abort;
   wire start      = (sc_start | hw_start | cont_next) & ~stop_abort;
   wire [5:0] sample_len = cfg_q.long_sample_select ? 6'(ACV_SAMPLE_LONG_HALF)
                                                    : 6'(ACV_SAMPLE_SHORT_HALF);
   wire cmp_hi     = cmp_s_q[1];
   wire [ACV_EV_W-1:0] ev = {busy & (stop_abort | sc_wr), done};

   // Two-stage synchronisers for pins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         stop_s_q    <= 2'b00;
         trig_s_q    <= 2'b00;
         cmp_s_q     <= 2'b00;
         trig_prev_q <= 1'b0;
      end
      else
      begin
         stop_s_q    <= {stop_s_q[0], stop_mode};
         trig_s_q    <= {trig_s_q[0], hw_trigger};
         cmp_s_q     <= {cmp_s_q[0], comparator_in};
         trig_prev_q <= trig_s_q[1];
      end
   end

   // Half converter-clock enable pulses
   acv_clkdiv #(.DW(ACV_DIV_W)) i_acv_clkdiv
   (
      .pclk      (pclk),
      .presetn   (presetn),
      .run       (busy),
      .div       (cfg_q.div),
      .half_tick (half_tick)
   );

   // Nearest-code rounding of the extended word
   acv_round #(.RW(RES_W)) i_acv_round
   (
      .raw  (sar_q),
      .code (rounded)
   );

   // Sequencer: sample window then one trial bit per converter clock
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q    <= ACV_IDLE;
         half_cnt_q <= '0;
         sar_q      <= '0;
         bit_q      <= '0;
      end
      else if (stop_abort || sc_wr)
      begin
         state_q    <= sc_start && !stop_abort ? ACV_SAMPLE : ACV_IDLE;
         half_cnt_q <= '0;
         sar_q      <= '0;
         bit_q      <= {1'b1, {RES_W{1'b0}}};
      end
      else
      begin
         case (state_q)
            ACV_IDLE:
            begin
               if (start)
               begin
                  state_q    <= ACV_SAMPLE;
                  half_cnt_q <= '0;
                  sar_q      <= '0;
                  bit_q      <= {1'b1, {RES_W{1'b0}}};
               end
            end
            ACV_SAMPLE:
            begin
               if (half_tick)
               begin
                  half_cnt_q <= half_cnt_q + 6'd1;
                  if (half_cnt_q == sample_len - 6'd1)
                  begin
                     state_q    <= ACV_CONV;
                     half_cnt_q <= '0;
                  end
               end
            end
            ACV_CONV:
            begin
               // Bit decision on every second half tick (one converter clock)
               if (half_tick)
               begin
                  half_cnt_q <= {5'd0, ~half_cnt_q[0]};
                  if (half_cnt_q[0])
                  begin
                     sar_q <= cmp_hi ? (sar_q | bit_q) : sar_q;
                     bit_q <= bit_q >> 1;
                     if (bit_q[0])
                        state_q <= ACV_XFER;
                  end
               end
            end
            ACV_XFER:
            begin
               // Single mode falls back to low-power idle on its own
               state_q    <= cont_next ? ACV_SAMPLE : ACV_IDLE;
               half_cnt_q <= '0;
               sar_q      <= '0;
               bit_q      <= {1'b1, {RES_W{1'b0}}};
            end
            default:
               state_q <= ACV_IDLE;
         endcase
      end
   end

   // Software registers and result holding
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sc_q      <= ACV_SC_RESET;
         cfg_q     <= '{1'b0, 1'b0, 1'b0, ACV_DIV_RESET};
         result_q  <= '0;
         stopped_q <= 1'b0;
      end
      else
      begin
         if (sc_wr)
            sc_q[ACV_IEN_BIT:0] <= pwdata[ACV_IEN_BIT:0];
         // Completion sets over any same-cycle clear
         if (done)
            sc_q[ACV_COMPLETE_BIT] <= 1'b1;
         else if (sc_wr || rl_rd)
            sc_q[ACV_COMPLETE_BIT] <= 1'b0;
         if (wr && sel_cfg)
         begin
            cfg_q.async_clock_select  <= pwdata[ACV_ASYNC_BIT];
            cfg_q.long_sample_select  <= pwdata[ACV_LONG_BIT];
            cfg_q.hw_trigger_mode_bit <= pwdata[ACV_HWTRIG_BIT];
            cfg_q.div                 <= pwdata[ACV_DIV_LSB +: ACV_DIV_W];
         end
         // Results change only when a conversion completes
         if (done)
            result_q <= rounded;
         // Once aborted by stop, only a control write rearms
         if (stop_abort)
            stopped_q <= 1'b1;
         else if (sc_wr)
            stopped_q <= 1'b0;
      end
   end

   // Conversion interrupt line and sticky event status
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         conv_irq_q <= 1'b0;
         ist_q      <= '0;
         imask_q    <= '0;
      end
      else
      begin
         if (done && ien)
            conv_irq_q <= 1'b1;
         else if (sc_wr || rl_rd || rh_rd)
            conv_irq_q <= 1'b0;
         ist_q <= ev | (ist_q & ~((wr && sel_ist) ? pwdata[ACV_EV_W-1:0] : '0));
         if (wr && sel_msk)
            imask_q <= pwdata[ACV_EV_W-1:0];
      end
   end

   // Read data selection
   wire [31:0] cfg_rd = {16'h0000, cfg_q.div, 3'b000, ~busy, busy,
                         cfg_q.hw_trigger_mode_bit, cfg_q.long_sample_select,
                         cfg_q.async_clock_select};
   wire [31:0] rd_mux =
      sel_sc  ? {24'h000000, sc_q} :
      sel_rh  ? {30'h0000000, result_q[RES_W-1:8]} :
      sel_rl  ? {24'h000000, result_q[7:0]} :
      sel_cfg ? cfg_rd :
      sel_ist ? {30'h0000000, ist_q} :
      sel_msk ? {30'h0000000, imask_q} :
      sel_sar ? {21'h00000, sar_q} : 32'h00000000;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h00000000;
      else if (psel && !penable && !pwrite)
         prdata <= rd_mux;
   end

   // Outputs
   assign pready       = 1'b1;
   assign pslverr      = acc & ~mapped;
   assign sar_trial    = sar_q | bit_q;
   assign converter_on = busy;
   assign channel_out  = chan;
   assign conv_irq     = conv_irq_q;
   assign irq          = conv_irq_q | (|(ist_q & imask_q));
endmodule : acv_ctrl
`default_nettype wire

/* test/acv_ctrl_asserts.sv */
// Port-level checker for the converter control
`timescale 1ns/1ps
`default_nettype none
module acv_ctrl_chk
   import acv_pkg::*;
#(
   parameter int RES_W = ACV_RES_BITS
)
(
   input wire logic           pclk,
   input wire logic           presetn,
   input wire logic           psel,
   input wire logic           penable,
   input wire logic           pwrite,
   input wire logic [11:0]    paddr,
   input wire logic [31:0]    pwdata,
   input wire logic [31:0]    prdata,
   input wire logic           pready,
   input wire logic           pslverr,
   input wire logic           stop_mode,
   input wire logic           wait_mode,
   input wire logic           hw_trigger,
   input wire logic           comparator_in,
   input wire logic [RES_W:0] sar_trial,
   input wire logic           converter_on,
   input wire logic [4:0]     channel_out,
   input wire logic           conv_irq,
   input wire logic           irq
);
   logic acc;
   logic wr_sc;
   logic rd_res;
   logic async_q;
   logic hw_q;
   logic ien_q;
   logic cont_q;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Completed accesses by register
   assign acc    = psel && penable && pready;
   assign wr_sc  = acc && pwrite && (paddr == ACV_STATUS_CONTROL_OFF);
   assign rd_res = acc && !pwrite && (paddr == ACV_RESULT_LOW_OFF);
   // Shadow copies of the control bits written by software
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         {async_q, hw_q, ien_q, cont_q} <= 4'h0;
      else if (acc && pwrite && (paddr == ACV_CONFIG_OFF))
         {async_q, hw_q} <= {pwdata[ACV_ASYNC_BIT], pwdata[ACV_HWTRIG_BIT]};
      else if (wr_sc)
         {ien_q, cont_q} <= {pwdata[ACV_IEN_BIT], pwdata[ACV_CONT_BIT]};
   property p_irq_en;
      $rose(conv_irq) |-> ien_q && irq;
   endproperty
   a_irq_en: assert property (p_irq_en) else $error("irq without enable");
   property p_done_idle;
      $rose(conv_irq) && !cont_q |-> ##[0:1] !converter_on;
   endproperty
   a_done_idle: assert property (p_done_idle) else $error("no idle after done");
   property p_wr_clr;
      wr_sc |=> !conv_irq;
   endproperty
   a_wr_clr: assert property (p_wr_clr) else $error("irq kept after write");
   property p_rd_clr;
      rd_res |=> !conv_irq;
   endproperty
   a_rd_clr: assert property (p_rd_clr) else $error("irq kept after read");
   property p_start;
      wr_sc && !hw_q && !stop_mode && pwdata[4:0] != ACV_CH_OFF |-> ##[1:3] converter_on;
   endproperty
   a_start: assert property (p_start) else $error("no start on write");
   property p_off;
      wr_sc && pwdata[4:0] == ACV_CH_OFF |-> ##[1:3] !converter_on && channel_out == ACV_CH_OFF;
   endproperty
   a_off: assert property (p_off) else $error("not off");
   property p_stop;
      $rose(stop_mode) && !async_q |-> ##[1:5] !converter_on;
   endproperty
   a_stop: assert property (p_stop) else $error("stop did not abort");
   property p_stop_hold;
      stop_mode && !async_q && !converter_on && !wr_sc |=> !converter_on;
   endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("restart in stop");
   property p_err;
      acc && paddr > ACV_SAR_DATA_OFF |-> pslverr;
   endproperty
   a_err: assert property (p_err) else $error("no slave error");
   c_done: cover property ($rose(conv_irq));
   c_abort: cover property (stop_mode && !async_q && $fell(converter_on));
   c_async: cover property (stop_mode && async_q && $rose(conv_irq));
endmodule : acv_ctrl_chk
bind acv_ctrl acv_ctrl_chk #(.RES_W(RES_W)) i_acv_ctrl_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .stop_mode(stop_mode),
   .wait_mode(wait_mode), .hw_trigger(hw_trigger), .comparator_in(comparator_in),
   .sar_trial(sar_trial), .converter_on(converter_on), .channel_out(channel_out),
   .conv_irq(conv_irq), .irq(irq));
`default_nettype wire

/* test/acv_ctrl_tb.sv */
// Self-checking bench for the converter control
`timescale 1ns/1ps
`default_nettype none
module acv_ctrl_tb;
   import acv_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn, psel, penable, pwrite, pready, pslverr, err;
   logic        stop_mode, wait_mode, hw_trigger, comparator_in;
   logic        converter_on, conv_irq, irq;
   logic [11:0] paddr, vq;
   logic [31:0] pwdata, prdata, rd;
   logic [10:0] sar_trial;
   logic [4:0]  channel_out;
   int          n_errors = 0;
   int          compares = 0;
   int          cyc = 0;
   acv_ctrl i_acv_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .stop_mode(stop_mode), .wait_mode(wait_mode),
      .hw_trigger(hw_trigger), .comparator_in(comparator_in), .sar_trial(sar_trial),
      .converter_on(converter_on), .channel_out(channel_out), .conv_irq(conv_irq),
      .irq(irq));
   always #4 pclk = ~pclk;
   // Analog input in quarter steps against the trial word
   always @(posedge pclk)
      comparator_in <= (vq > {sar_trial, 1'b0});
   // Hang guard
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         n_errors++;
         final_report();
      end
   end
   task final_report();
      if (n_errors == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : final_report
   task chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e)
      begin
         n_errors++;
         $display("ERROR %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task wirq();
      int n;
      n = 0;
      while (conv_irq !== 1'b1 && n < 2000)
      begin
         @(posedge pclk);
         n++;
      end
      rd = n;
   endtask : wirq
   task t_reset();
      apb(0, ACV_STATUS_CONTROL_OFF, 0);
      chk(rd, 32'h1F);
      chk(channel_out, 5'h1F);
      apb(0, ACV_CONFIG_OFF, 0);
      chk(rd[15:8], ACV_DIV_RESET);
      apb(0, 12'h020, 0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
   endtask : t_reset
   task t_conv(input logic [11:0] v, input logic [9:0] e, input logic ie);
      int n;
      vq = v;
      apb(1, ACV_STATUS_CONTROL_OFF, {25'h0, ie, 6'h03});
      n = 0;
      do
      begin
         apb(0, ACV_STATUS_CONTROL_OFF, 0);
         n++;
      end
      while (rd[7] !== 1'b1 && n < 300);
      chk(rd[7], 1'b1);
      chk(conv_irq, ie);
      chk(converter_on, 1'b0);
      apb(0, ACV_RESULT_HIGH_OFF, 0);
      chk(rd[1:0], e[9:8]);
      chk(conv_irq, 1'b0);
      apb(0, ACV_RESULT_LOW_OFF, 0);
      chk(rd[7:0], e[7:0]);
      apb(0, ACV_STATUS_CONTROL_OFF, 0);
      chk(rd[7], 1'b0);
   endtask : t_conv
   task t_win();
      int s;
      apb(1, ACV_CONFIG_OFF, 32'h100);
      apb(1, ACV_STATUS_CONTROL_OFF, 32'h43);
      wirq();
      s = rd;
      apb(0, ACV_RESULT_LOW_OFF, 0);
      apb(1, ACV_CONFIG_OFF, 32'h102);
      apb(1, ACV_STATUS_CONTROL_OFF, 32'h43);
      wirq();
      s = int'(rd) - s;
      apb(0, ACV_RESULT_LOW_OFF, 0);
      // Divider 1 gives a half tick every 2 bus clocks
      chk(s, 2 * (ACV_SAMPLE_LONG_HALF - ACV_SAMPLE_SHORT_HALF));
   endtask : t_win
   task t_stop();
      // Aborted conversion would give a different result
      vq = 12'h001;
      apb(1, ACV_CONFIG_OFF, 32'h300);
      apb(1, ACV_IRQ_MASK_OFF, 32'h2);
      apb(1, ACV_STATUS_CONTROL_OFF, 32'h43);
      repeat (20) @(posedge pclk);
      stop_mode <= 1'b1;
      repeat (10) @(posedge pclk);
      chk({converter_on, irq}, 2'b01);
      apb(1, ACV_IRQ_MASK_OFF, 0);
      chk(irq, 1'b0);
      apb(1, ACV_IRQ_MASK_OFF, 32'h2);
      apb(1, ACV_IRQ_STATUS_OFF, 32'h2);
      chk(irq, 1'b0);
      stop_mode <= 1'b0;
      repeat (300) @(posedge pclk);
      chk({converter_on, conv_irq}, 2'b00);
      apb(0, ACV_RESULT_LOW_OFF, 0);
      chk(rd[7:0], 8'hFF);
      apb(1, ACV_STATUS_CONTROL_OFF, 32'h43);
      wirq();
      chk(conv_irq, 1'b1);
      apb(0, ACV_RESULT_LOW_OFF, 0);
      chk(rd[7:0], 8'h00);
   endtask : t_stop
   // Write with channel all ones aborts and stays off
   task t_off();
      apb(1, ACV_STATUS_CONTROL_OFF, 32'h43);
      repeat (20) @(posedge pclk);
      apb(1, ACV_STATUS_CONTROL_OFF, 32'h5F);
      repeat (300) @(posedge pclk);
      chk({converter_on, conv_irq, channel_out}, {2'b00, ACV_CH_OFF});
      apb(0, ACV_IRQ_STATUS_OFF, 0);
      chk(rd[ACV_EV_ABORT], 1'b1);
      apb(1, ACV_IRQ_STATUS_OFF, 32'h2);
   endtask : t_off
   // Four results on the async clock averaged by software
   task t_avg();
      int sum;
      sum = 0;
      vq = 12'h557;
      apb(1, ACV_CONFIG_OFF, 32'h301);
      repeat (4)
      begin
         apb(1, ACV_STATUS_CONTROL_OFF, 32'h43);
         wirq();
         apb(0, ACV_RESULT_HIGH_OFF, 0);
         sum = sum + (int'(rd[1:0]) << 8);
         apb(0, ACV_RESULT_LOW_OFF, 0);
         sum = sum + int'(rd[7:0]);
      end
      chk(sum / 4, 32'h156);
   endtask : t_avg
   task t_async();
      apb(1, ACV_CONFIG_OFF, 32'h301);
      apb(1, ACV_STATUS_CONTROL_OFF, 32'h43);
      stop_mode <= 1'b1;
      wirq();
      chk(conv_irq, 1'b1);
      apb(0, ACV_RESULT_LOW_OFF, 0);
      apb(1, ACV_CONFIG_OFF, 32'h305);
      repeat (300) @(posedge pclk);
      chk(converter_on, 1'b0);
      hw_trigger <= 1'b1;
      wirq();
      chk(conv_irq, 1'b1);
      hw_trigger <= 1'b0;
      apb(0, ACV_RESULT_LOW_OFF, 0);
      repeat (300) @(posedge pclk);
      chk(converter_on, 1'b0);
      stop_mode <= 1'b0;
   endtask : t_async
   // Main sequence
   initial
   begin
      {presetn, psel, penable, pwrite, stop_mode, wait_mode, hw_trigger} = '0;
      paddr = '0;
      pwdata = '0;
      vq = '0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_conv(12'h001, 10'h000, 1'b1);
      t_conv(12'h557, 10'h156, 1'b0);
      wait_mode <= 1'b1;
      t_conv(12'h801, 10'h200, 1'b1);
      wait_mode <= 1'b0;
      t_conv(12'hFFF, 10'h3FF, 1'b1);
      t_win();
      t_stop();
      t_off();
      t_avg();
      t_async();
      final_report();
   end
endmodule : acv_ctrl_tb
`default_nettype wire
